//--- hdl/motion_axis_defines.vh
// Purpose: shared constants for the motion axis logic
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz clock
// Notes:   offsets are byte addresses of aligned words
`ifndef MOTION_AXIS_DEFINES_VH
`define MOTION_AXIS_DEFINES_VH
// axis type codes
`define AXIS_TYPE_VIRTUAL 8'h00
`define AXIS_TYPE_ENC_IN  8'h03
`define AXIS_TYPE_SERVO   8'h0d
`define AXIS_TYPE_ENC_OUT 8'h0e
// limit input select codes for the drive's own inputs
`define LIM_SEL_DRV_FWD   8'h12
`define LIM_SEL_DRV_REV   8'h13
// encoder output scaling
`define ENC_OUT_RATIO     7'h40
`define Z_PERIOD_EDGES    13'h1000
// register offsets
`define REG_CTRL          8'h00
`define REG_AXIS1_TYPE    8'h04
`define REG_FE_MAX        8'h08
`define REG_LIM_SEL       8'h0c
`define REG_DEMAND0       8'h10
`define REG_MEASURED0     8'h14
`define REG_AXIS1_DEMAND  8'h18
`define REG_AXIS1_POS     8'h1c
`define REG_AXIS2_POS     8'h20
`define REG_STATE_WORD    8'h24
`define REG_IRQ_STATUS    8'h28
`define REG_IRQ_MASK      8'h2c
`define REG_SPEED_REF     8'h30
`define REG_TORQUE_REF    8'h34
`define REG_LOOP_REF      8'h38
`define REG_AXIS2_DEMAND  8'h3c
// control register fields
`define CTRL_ENABLE       0
`define CTRL_MODE_LSB     1
`define CTRL_LINK_OK      3
// servo output modes
`define MODE_CLOSED       2'h0
`define MODE_OPEN         2'h1
`define MODE_TORQUE       2'h2
// state word / irq status fields
`define ST_MOTION_ERR     0
`define ST_FWD_LIMIT      1
`define ST_REV_LIMIT      2
`define ST_LINK_FAIL      3
// reset values
`define RST_AXIS1_TYPE    8'h03
`define RST_FE_MAX        32'h0000_1000
// link watchdog timeout in us and clock rate in MHz
`define LINK_TIMEOUT_US   1000
`define CLK_MHZ           100
`endif

//--- hdl/motion_axis_encoder_fault_logic.v
// What this block does
// - axis functions chosen by axis type codes
// - encoder input counts every edge, x4
// - encoder output quadrature tracks internal position
// - one output pulse per 64 counts
// - index marker every 4096 generated edges
// - following error excess: error, disable, halt
// - limit inputs selected by codes 18/19
// - drive limit reached sets state word bit
// - link failure forces fail-safe halt
// - virtual axis measured equals demanded position
// - closed, open speed or torque reference
//
// Purpose: per-axis motion logic with encoder and fault handling
// Assumes: AXI4-Lite master, one write and one read at a time
// Notes:   pin inputs pass two flops before use
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "motion_axis_defines.vh"
module motion_axis_encoder_fault_logic #(
	parameter LINK_TIMEOUT_CYC = `LINK_TIMEOUT_US * `CLK_MHZ
) (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        encInA,
	input  wire        encInB,
	input  wire        drvFwdLimit,
	input  wire        drvRevLimit,
	input  wire        extFwdLimit,
	input  wire        extRevLimit,
	input  wire        linkAlive,
	output reg         encOutA,
	output reg         encOutB,
	output reg         encOutZ,
	output reg         servoEnable,
	output reg         motionHalt,
	output reg  [1:0]  servoMode,
	output reg  [31:0] servoRef,
	output reg         irq
);
	// synchronisers: stage 1 is read only by stage 2
	reg  [6:0] sync1;
	reg  [6:0] sync2;
	wire       sA    = sync2[0];
	wire       sB    = sync2[1];
	wire       dFwd  = sync2[2];
	wire       dRev  = sync2[3];
	wire       eFwd  = sync2[4];
	wire       eRev  = sync2[5];
	wire       alive = sync2[6];
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
		end else begin
			sync1 <= {linkAlive, extRevLimit, extFwdLimit, drvRevLimit,
				drvFwdLimit, encInB, encInA};
			sync2 <= sync1;
		end
	end
	reg  [31:0] ctrl;
	reg  [7:0]  axis1Type;
	reg  [31:0] feMax;
	reg  [15:0] limSel;
	reg  [31:0] demand0;
	reg  [31:0] measured0;
	reg  [31:0] axis1Demand;
	reg  [31:0] axis1Pos;
	reg  [31:0] axis2Demand;
	reg  [3:0]  irqStatus;
	reg  [3:0]  irqMask;
	reg  [31:0] speedRef;
	reg  [31:0] torqueRef;
	reg  [31:0] loopRef;
	reg  [3:0]  stateWord;
	reg  [6:0]  divCnt;
	reg  [1:0]  quadPhase;
	reg  [11:0] edgeCnt;
	reg  [31:0] linkCnt;
	wire countUp;
	wire countDown;
	quad_decoder u_dec (
		.clk       (clk),
		.nrst      (nrst),
		.phaseA    (sA),
		.phaseB    (sB),
		.countUp   (countUp),
		.countDown (countDown)
	);
	// limit source by select code; other codes pick the external pins
	function limPick;
		input [7:0] sel;
		input [7:0] drvCode;
		input       drvPin;
		input       extPin;
		begin
			limPick = (sel == drvCode) ? drvPin : extPin;
		end
	endfunction
	wire fwdHit = limPick(limSel[7:0], `LIM_SEL_DRV_FWD, dFwd, eFwd);
	wire revHit = limPick(limSel[15:8], `LIM_SEL_DRV_REV, dRev, eRev);
	wire [31:0] feDiff = demand0 - measured0;
	wire [31:0] feAbs  = feDiff[31] ? (32'h0 - feDiff) : feDiff;
	wire        feTrip = (feAbs > feMax);
	// link watchdog expiry; bit 31 keeps the last alive level, not time
	wire linkFail = ctrl[`CTRL_LINK_OK] &&
		(linkCnt[30:0] >= LINK_TIMEOUT_CYC);
	wire [3:0] events = {linkFail, revHit, fwdHit, feTrip};
	wire       halted = |stateWord[`ST_LINK_FAIL:`ST_MOTION_ERR];
	// write channel: address and data may arrive in either order
	reg        awHeld;
	reg        wHeld;
	reg [7:0]  awAddr;
	reg [31:0] wData;
	reg [3:0]  wStrb;
	wire       doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire [31:0] wMask = {{8{wStrb[3]}}, {8{wStrb[2]}},
		{8{wStrb[1]}}, {8{wStrb[0]}}};
	wire [31:0] wr32 = wData & wMask;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
			awAddr <= 8'h00;
			wData  <= 32'h0;
			wStrb  <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= !awHeld && !s_axi_awready;
			s_axi_wready  <= !wHeld && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr > `REG_AXIS2_DEMAND ||
					awAddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// register writes and hardware state updates
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl        <= 32'h0;
			axis1Type   <= `RST_AXIS1_TYPE;
			feMax       <= `RST_FE_MAX;
			limSel      <= {`LIM_SEL_DRV_REV, `LIM_SEL_DRV_FWD};
			demand0     <= 32'h0;
			axis1Demand <= 32'h0;
			axis2Demand <= 32'h0;
			irqMask     <= 4'h0;
			speedRef    <= 32'h0;
			torqueRef   <= 32'h0;
			loopRef     <= 32'h0;
			irqStatus   <= 4'h0;
			stateWord   <= 4'h0;
			measured0   <= 32'h0;
			axis1Pos    <= 32'h0;
			linkCnt     <= 32'h0;
		end else begin
			if (doWrite) begin
				case (awAddr)
				`REG_CTRL:         ctrl <= wr32;
				`REG_AXIS1_TYPE:   axis1Type <= wr32[7:0];
				`REG_FE_MAX:       feMax <= wr32;
				`REG_LIM_SEL:      limSel <= wr32[15:0];
				`REG_DEMAND0:      demand0 <= wr32;
				`REG_MEASURED0:    measured0 <= wr32;
				`REG_AXIS1_DEMAND: axis1Demand <= wr32;
				`REG_AXIS2_DEMAND: axis2Demand <= wr32;
				`REG_IRQ_MASK:     irqMask <= wr32[3:0];
				`REG_SPEED_REF:    speedRef <= wr32;
				`REG_TORQUE_REF:   torqueRef <= wr32;
				`REG_LOOP_REF:     loopRef <= wr32;
				default: ;
				endcase
			end
			// set wins over write-one-to-clear
			irqStatus <= (irqStatus & ~((doWrite &&
				awAddr == `REG_IRQ_STATUS) ? wr32[3:0] : 4'h0)) | events;
			// error, limit and link flags in state word; all latch
			stateWord <= (stateWord & ~((doWrite &&
				awAddr == `REG_STATE_WORD) ? wr32[3:0] : 4'h0)) | events;
			// watchdog restarts on each alive level change
			if (alive != linkCnt[31] || !ctrl[`CTRL_LINK_OK])
				linkCnt <= {alive, 31'h0};
			else if (linkCnt[30:0] != 31'h7fffffff)
				linkCnt <= linkCnt + 32'h1;
			// axis 1 function by type code; x4 count
			if (axis1Type == `AXIS_TYPE_ENC_IN) begin
				if (countUp)
					axis1Pos <= axis1Pos + 32'h1;
				else if (countDown)
					axis1Pos <= axis1Pos - 32'h1;
			end else begin
				// virtual and output axes follow demand
				axis1Pos <= axis1Demand;
			end
		end
	end
	// encoder output stepping toward axis 1 position
	wire encOutOn = (axis1Type == `AXIS_TYPE_ENC_OUT);
	reg  [31:0] outTrack;
	wire        stepUp = encOutOn && $signed(axis1Pos) > $signed(outTrack);
	wire        stepDn = encOutOn && $signed(axis1Pos) < $signed(outTrack);
	// phase order 00, 01, 11, 10 counts up at the decoder; +3 steps back
	wire [1:0]  next_quadPhase = quadPhase + (stepUp ? 2'h1 : 2'h3);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			outTrack  <= 32'h0;
			divCnt    <= 7'h00;
			quadPhase <= 2'h0;
			edgeCnt   <= 12'h000;
			encOutA   <= 1'b0;
			encOutB   <= 1'b0;
			encOutZ   <= 1'b0;
		end else begin
			encOutZ <= 1'b0;
			if (stepUp || stepDn) begin
				outTrack <= stepUp ? outTrack + 32'h1 : outTrack - 32'h1;
				// one output pulse per 64 counts (16 per edge)
				if (divCnt == (`ENC_OUT_RATIO / 7'h4) - 7'h1) begin
					divCnt <= 7'h00;
					quadPhase <= next_quadPhase;
					encOutA   <= next_quadPhase[1];
					encOutB   <= ^next_quadPhase;
					edgeCnt <= edgeCnt + 12'h001;
					if (edgeCnt == 12'hfff)
						encOutZ <= 1'b1;
				end else begin
					divCnt <= divCnt + 7'h01;
				end
			end
		end
	end
	// servo outputs and interrupt, all registered
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			servoEnable <= 1'b0;
			motionHalt  <= 1'b0;
			servoMode   <= `MODE_CLOSED;
			servoRef    <= 32'h0;
			irq         <= 1'b0;
		end else begin
			// disable drive and halt on any fault
			servoEnable <= ctrl[`CTRL_ENABLE] && !halted && !(|events);
			motionHalt  <= halted || (|events);
			servoMode <= ctrl[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
			case (ctrl[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB])
			`MODE_OPEN:   servoRef <= halted ? 32'h0 : speedRef;
			`MODE_TORQUE: servoRef <= halted ? 32'h0 : torqueRef;
			default:      servoRef <= halted ? 32'h0 : loopRef;
			endcase
			irq <= |(irqStatus & irqMask);
		end
	end
	// read channel
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= 2'h0;
				case (s_axi_araddr)
				`REG_CTRL:         s_axi_rdata <= ctrl;
				`REG_AXIS1_TYPE:   s_axi_rdata <= {24'h0, axis1Type};
				`REG_FE_MAX:       s_axi_rdata <= feMax;
				`REG_LIM_SEL:      s_axi_rdata <= {16'h0, limSel};
				`REG_DEMAND0:      s_axi_rdata <= demand0;
				`REG_MEASURED0:    s_axi_rdata <= measured0;
				`REG_AXIS1_DEMAND: s_axi_rdata <= axis1Demand;
				`REG_AXIS1_POS:    s_axi_rdata <= axis1Pos;
				`REG_AXIS2_POS:    s_axi_rdata <= axis2Demand;
				`REG_STATE_WORD:   s_axi_rdata <= {28'h0, stateWord};
				`REG_IRQ_STATUS:   s_axi_rdata <= {28'h0, irqStatus};
				`REG_IRQ_MASK:     s_axi_rdata <= {28'h0, irqMask};
				`REG_SPEED_REF:    s_axi_rdata <= speedRef;
				`REG_TORQUE_REF:   s_axi_rdata <= torqueRef;
				`REG_LOOP_REF:     s_axi_rdata <= loopRef;
				`REG_AXIS2_DEMAND: s_axi_rdata <= axis2Demand;
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // motion_axis_encoder_fault_logic

//--- hdl/quad_decoder.v
// Purpose: x4 quadrature decoder producing count pulses
// Assumes: inputs already synchronised to clk
// Notes:   an illegal double transition is dropped
`timescale 1ns/1ps
module quad_decoder (
	input  wire        clk,
	input  wire        nrst,
	input  wire        phaseA,
	input  wire        phaseB,
	output reg         countUp,
	output reg         countDown
);
	reg  [1:0] prev;
	wire [3:0] trans = {prev, phaseA, phaseB};
	// every edge of either phase counts; order gives direction
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev      <= 2'h0;
			countUp   <= 1'b0;
			countDown <= 1'b0;
		end else begin
			prev      <= {phaseA, phaseB};
			countUp   <= (trans == 4'h1) || (trans == 4'h7) ||
				(trans == 4'he) || (trans == 4'h8);
			countDown <= (trans == 4'h2) || (trans == 4'hb) ||
				(trans == 4'hd) || (trans == 4'h4);
		end
	end
endmodule // quad_decoder

//--- test/drive_side_model.sv
// Purpose: far side model, quadrature source and link heartbeat
// Assumes: one step of the pattern every four clocks while run
// Notes:   the heartbeat stops when beat is low
`timescale 1ns/1ps
module drive_side_model (
	input  wire       clk,
	input  wire       run,
	input  wire       dir,
	input  wire       beat,
	output reg        encA,
	output reg        encB,
	output reg        linkAlive
);
	reg [1:0] sub;
	reg [1:0] pos;
	reg [1:0] hb;
	initial begin
		sub = 2'h0;
		pos = 2'h0;
		hb = 2'h0;
		linkAlive = 1'b0;
	end
	// gray steps
	// slow steps so the two-flop sync never sees two changes at once
	always @(posedge clk) begin
		sub <= run ? sub + 2'h1 : 2'h0;
		if (run && sub == 2'h3)
			pos <= dir ? pos - 2'h1 : pos + 2'h1;
	end
	always @* begin
		encA = pos[1];
		encB = pos[1] ^ pos[0];
	end
	always @(posedge clk) begin
		hb <= hb + 2'h1;
		if (beat && hb == 2'h3)
			linkAlive <= ~linkAlive;
	end
endmodule // drive_side_model

//--- test/motion_axis_encoder_fault_logic_props.sv
// Purpose: port checker for the motion axis block
// Assumes: one clock, nrst active low
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module motion_axis_props (
	input  wire        clk,
	input  wire        nrst,
	input  wire        s_axi_awvalid,
	input  wire        s_axi_awready,
	input  wire        s_axi_wvalid,
	input  wire        s_axi_wready,
	input  wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire        s_axi_arvalid,
	input  wire        s_axi_arready,
	input  wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [31:0] s_axi_rdata,
	input  wire        encOutA,
	input  wire        encOutB,
	input  wire        encOutZ,
	input  wire        servoEnable,
	input  wire        motionHalt,
	input  wire [31:0] servoRef
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_HALT_OFF: assert property (motionHalt && $past(motionHalt)
		|-> !servoEnable && servoRef == 32'h0) else $error("halt leak");
	AST_QUAD_GRAY: assert property (!($changed(encOutA)
		&& $changed(encOutB))) else $error("both phases moved");
	AST_Z_PULSE: assert property (encOutZ |=> !encOutZ)
		else $error("index too long");
	AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write answer");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("bvalid dropped");
	AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("no read answer");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	AST_AW_TOGGLE: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready) else $error("awready stayed");
	AST_W_TOGGLE: assert property (s_axi_wvalid && s_axi_wready
		|=> !s_axi_wready) else $error("wready stayed");
endmodule // motion_axis_props
bind motion_axis_encoder_fault_logic motion_axis_props motion_axis_props_i (
	.clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.encOutA(encOutA), .encOutB(encOutB), .encOutZ(encOutZ),
	.servoEnable(servoEnable), .motionHalt(motionHalt), .servoRef(servoRef));

//--- test/test_motion_axis_encoder_fault_logic.sv
// Purpose: register level tests of the motion axis block
// Assumes: short link timeout of 20 cycles
// Notes:   encoder count direction is checked as a round trip
`timescale 1ns/1ps
module test_motion_axis_encoder_fault_logic;
	reg         clk = 0, nrst = 0;
	reg  [7:0]  awaddr = 0, araddr = 0;
	reg  [31:0] wdata = 0, rv;
	reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg         run = 0, dir = 0, beat = 1;
	reg         dFwd = 0, dRev = 0, eFwd = 0, eRev = 0, pA = 0, pB = 0;
	wire        awready, wready, bvalid, arready, rvalid, encA, encB;
	wire        linkAlive, oA, oB, oZ, servoEnable, motionHalt, irq;
	wire [1:0]  bresp, rresp, servoMode;
	wire [31:0] rdata, servoRef;
	integer     err_count = 0, num_checks = 0, edges = 0, i, base;
	integer     zCount = 0;
	always #5 clk = ~clk;
	motion_axis_encoder_fault_logic #(.LINK_TIMEOUT_CYC(20))
	motion_axis_encoder_fault_logic_i (
		.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .encInA(encA), .encInB(encB),
		.drvFwdLimit(dFwd), .drvRevLimit(dRev), .extFwdLimit(eFwd),
		.extRevLimit(eRev), .linkAlive(linkAlive), .encOutA(oA),
		.encOutB(oB), .encOutZ(oZ), .servoEnable(servoEnable),
		.motionHalt(motionHalt), .servoMode(servoMode),
		.servoRef(servoRef), .irq(irq));
	drive_side_model drive_side_model_i (.clk(clk), .run(run), .dir(dir),
		.beat(beat), .encA(encA), .encB(encB), .linkAlive(linkAlive));
	// count generated edges on either output phase, and index pulses
	always @(posedge clk) begin
		if (oA !== pA || oB !== pB)
			edges <= edges + 1;
		if (oZ === 1'b1)
			zCount <= zCount + 1;
		pA <= oA;
		pB <= oB;
	end
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				$display("mismatch %0t got %h want %h", $time, got, exp);
				err_count = err_count + 1;
			end
		end
	endtask
	// each channel released only at the edge where its ready is seen
	task wr(input [7:0] a, input [31:0] d);
		begin
			awaddr <= a; wdata <= d;
			awvalid <= 1; wvalid <= 1; bready <= 1;
			@(posedge clk);
			while (awvalid || wvalid || bready) begin
				if (awready) awvalid <= 0;
				if (wready) wvalid <= 0;
				if (bvalid) bready <= 0;
				@(posedge clk);
			end
		end
	endtask
	task rd(input [7:0] a, output [31:0] d);
		begin
			araddr <= a; arvalid <= 1; rready <= 1;
			@(posedge clk);
			while (arvalid || rready) begin
				if (arready) arvalid <= 0;
				if (rvalid) begin
					rready <= 0;
					d = rdata;
				end
				@(posedge clk);
			end
		end
	endtask
	task enc(input d, input integer n);
		begin
			dir <= d; run <= 1;
			repeat (4 * n) @(posedge clk);
			run <= 0;
			repeat (8) @(posedge clk);
		end
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		err_count = err_count + 1;
		wrap_up;
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		rd(8'h04, rv); chk(rv, 32'h3);
		rd(8'h08, rv); chk(rv, 32'h1000);
		rd(8'h0c, rv); chk(rv, 32'h1312);
		rd(8'h40, rv); chk(rresp, 2'h2);
		// unmapped write is refused and changes nothing
		wr(8'h40, 32'h1);
		chk(bresp, 2'h2);
		// closed, open speed and torque references in turn
		wr(8'h30, 32'h11); wr(8'h34, 32'h22); wr(8'h38, 32'h33);
		for (i = 0; i < 3; i = i + 1) begin
			wr(8'h00, 1 | (i << 1));
			repeat (3) @(posedge clk);
			chk(servoMode, i);
			chk(servoRef, i == 0 ? 32'h33 : i == 1 ? 32'h11 : 32'h22);
		end
		wr(8'h08, 32'h10); wr(8'h10, 32'h10);
		repeat (3) @(posedge clk);
		chk({motionHalt, servoEnable}, 2'b01);
		wr(8'h10, 32'h11);
		repeat (3) @(posedge clk);
		chk({motionHalt, servoEnable}, 2'b10);
		chk(servoRef, 0);
		rd(8'h24, rv); chk(rv[0], 1);
		wr(8'h10, 0); wr(8'h24, 32'h1);
		repeat (3) @(posedge clk);
		chk(motionHalt, 0);
		// limit on the drive pin, then moved to the board pins
		wr(8'h2c, 32'h2); dFwd <= 1;
		repeat (5) @(posedge clk);
		rd(8'h24, rv); chk(rv[1], 1);
		chk(irq, 1);
		dFwd <= 0;
		repeat (5) @(posedge clk);
		wr(8'h28, 32'h2); wr(8'h24, 32'h2);
		repeat (3) @(posedge clk);
		chk(irq, 0);
		wr(8'h0c, 0); dFwd <= 1; eRev <= 1;
		repeat (5) @(posedge clk);
		rd(8'h24, rv); chk(rv[2:1], 2'b10);
		dFwd <= 0; eRev <= 0;
		repeat (5) @(posedge clk);
		wr(8'h24, 32'h6); wr(8'h28, 32'h6);
		// sixteen steps one way, then back to the start
		enc(0, 16);
		rd(8'h1c, rv); chk(rv == 16 || rv == 32'hfffffff0, 1);
		enc(1, 16);
		rd(8'h1c, rv); chk(rv, 0);
		wr(8'h04, 32'he); base = edges; wr(8'h18, 32'h100);
		i = 0;
		while (edges - base < 16 && i < 5000) begin
			@(posedge clk);
			i = i + 1;
		end
		repeat (200) @(posedge clk);
		chk(edges - base, 16);
		chk(zCount, 0);
		// run on to 4096 generated edges: exactly one index marker
		wr(8'h18, 32'h10000);
		i = 0;
		while (edges - base < 4096 && i < 70000) begin
			@(posedge clk);
			i = i + 1;
		end
		repeat (40) @(posedge clk);
		chk(edges - base, 4096);
		chk(zCount, 1);
		wr(8'h04, 0); wr(8'h18, 32'h5);
		rd(8'h1c, rv); chk(rv, 32'h5);
		wr(8'h3c, 32'h7);
		rd(8'h20, rv); chk(rv, 32'h7);
		// watchdog armed, then the heartbeat stops
		wr(8'h00, 32'h9);
		repeat (40) @(posedge clk);
		chk(motionHalt, 0);
		beat <= 0;
		repeat (60) @(posedge clk);
		chk({motionHalt, servoEnable}, 2'b10);
		rd(8'h24, rv); chk(rv[3], 1);
		wrap_up;
	end
endmodule // test_motion_axis_encoder_fault_logic
